// ==== dv/mrt_drive_model.sv ====
// Terminal wiring model in front of the ramp time selector.
// Assumes the bench sets its requests at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module mrt_drive_model (
  // Requests from the bench
  input  wire logic        runReq,
  input  wire logic [7:0]  termReq,
  input  wire logic [11:0] gainReq,
  // Pins toward the device
  output logic             runCmdPin,
  output logic [7:0]       terminalPin,
  output logic [11:0]      analogInputTwo,
  output logic [11:0]      analogInputThree
);
  // Plain wiring: pins move when the bench requests do, off the
  // sampling edge, so no race with a clocked copy of the requests
  assign runCmdPin        = runReq;
  assign terminalPin      = termReq;
  assign analogInputTwo   = gainReq;
  assign analogInputThree = ~gainReq; // Never mirrors input two
endmodule : mrt_drive_model
`default_nettype wire

// ==== dv/mrt_motor_ramp_time_selector_tb.sv ====
// Self-checking bench for the ramp time selector.
// Assumes shortened time units and a fixed maximum frequency.
`timescale 1ns/1ps
`default_nettype none
module mrt_motor_ramp_time_selector_tb;
  import mrt_pkg::*;
  localparam int FU = 100;  // Cycles per fine step
  localparam int CU = 1000; // Cycles per coarse step
  localparam int MF = 100;  // Maximum frequency code
  logic sys_clk = 1'b0, rst = 1'b1, runReq = 1'b0, runCmdPin;
  logic [7:0] termReq = '0, lf = 8'h0c, terminalPin, fn2 = '0, fn3 = '0;
  logic [11:0] gainReq = 12'h800, refFreq = '0, outFrequency, a2, a3;
  logic [7:0][7:0] fnSel = '0;
  mrt_ramp_cfg_t rc = '0;
  mrt_scurve_t sc = '0;
  mrt_hold_cfg_t hc = '0;
  mrt_status_t status;
  int miscompares = 0, total_checks = 0;

  initial forever #50 sys_clk = ~sys_clk;

  mrt_drive_model pm (.runReq(runReq), .termReq(termReq),
    .gainReq(gainReq), .runCmdPin(runCmdPin), .terminalPin(terminalPin),
    .analogInputTwo(a2), .analogInputThree(a3));

  mrt_motor_ramp_time_selector #(.NUM_TERM(8), .FINE_UNIT_CYC(FU),
    .COARSE_UNIT_CYC(CU)) uut (.sys_clk(sys_clk), .rst(rst),
    .runCmdPin(runCmdPin), .terminalPin(terminalPin), .analogInputTwo(a2),
    .analogInputThree(a3), .digitalInputFunctionSelect(fnSel),
    .analogInTwoFunction(fn2), .analogInThreeFunction(fn3),
    .rampCfg(rc), .scurveCfg(sc), .holdCfg(hc), .maxFrequency(12'(MF)),
    .freqReference(refFreq), .outFrequency(outFrequency), .status(status));

  // Pseudo-random source
  function automatic logic [7:0] lfsr(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr

  // Reference model: cycles to climb from zero to tgt
  function automatic int exp_up(int tgt, bit term, int sel);
    int n = 0;
    int p;
    int g = (fn2 == FN_AIN_GAIN) ? int'(gainReq) :
            (fn3 == FN_AIN_GAIN) ? int'(a3) : 2048;
    int u = rc.rampTimeResolution ? CU : FU;
    for (int f = 0; f < tgt; f++) begin
      // Terminals outrank the threshold
      p = term ? sel : (f < int'(rc.rampSwitchFrequency)) ? 3 : 0;
      n += int'(rc.accelTime[p]) * u * g / 2048 / MF;
      if (hc.startHoldTime != 0 && f == int'(hc.startHoldFrequency))
        n += int'(hc.startHoldTime) * CU;
    end
    return n + (int'(sc.accStart) + int'(sc.accEnd)) * FU / 2;
  endfunction : exp_up

  task automatic check_val(int got, int exp);
    total_checks++;
    if (got > exp + exp / 8 + 10 || got < exp - exp / 8 - 10) begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_pair(logic [1:0] got, logic [1:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check_pair

  // Run up to tgt, time the climb and count dwell cycles
  task automatic ramp(int tgt, bit term, int sel);
    int n = 0;
    int h = 0;
    int a = 0;
    refFreq = tgt[11:0];
    runReq = 1'b1;
    while (outFrequency !== tgt[11:0] && n < 40000) begin
      @(negedge sys_clk);
      n++;
      h += int'(status.holding);
      a += int'(status.accelerating);
    end
    check_val(n, exp_up(tgt, term, sel));
    check_val(h, int'(hc.startHoldTime) * CU);
    check_val(a + h, n);
  endtask : ramp

  // Stop and time the descent; decel times are equal in all pairs
  task automatic stop_ramp(int tgt);
    int n = 0;
    int h = 0;
    int u = rc.rampTimeResolution ? CU : FU;
    int e = int'(rc.decelTime[0]) * u * tgt / MF
          + (int'(sc.decStart) + int'(sc.decEnd)) * FU / 2
          + int'(hc.stopHoldTime) * CU;
    runReq = 1'b0;
    while (outFrequency !== 12'h000 && n < 40000) begin
      @(negedge sys_clk);
      n++;
      h += int'(status.holding);
    end
    check_val(n, e);
    check_val(h, int'(hc.stopHoldTime) * CU);
    repeat (4) @(negedge sys_clk);
    check_pair(status.state, ST_IDLE);
  endtask : stop_ramp

  task automatic stop_test;
    $display("Checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // Watchdog sized well above the planned run
  initial begin
    repeat (95000) @(posedge sys_clk);
    miscompares++;
    $display("Error at %0t: got %0h expected %0h", $time, 0, 1);
    stop_test();
  end

  initial begin
    for (int i = 0; i < 4; i++) begin
      rc.accelTime[i] = 16'(10 * (i + 1));
      rc.decelTime[i] = 16'h0005;
    end
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    // Terminal select with a live threshold that must lose
    fnSel[0] = FN_SEL_ONE;
    fnSel[1] = FN_SEL_TWO;
    rc.rampSwitchFrequency = 12'h01e;
    for (int r = 0; r < 3; r++) begin
      lf = lfsr(lf);
      termReq = lf;
      ramp(60, 1'b1, int'(lf[1:0]));
      check_pair({1'b0, status.autoSelect}, 2'h0);
      for (int s = 0; s < 4; s++) begin
        @(negedge sys_clk);
        termReq = {lf[7:2], 2'(s)};
        repeat (5) @(negedge sys_clk);
        check_pair(status.activePair, 2'(s));
      end
      stop_ramp(60);
      $display("Test terminal select %0d done", r);
    end
    // Automatic switching across the threshold, then disabled
    fnSel = '0;
    ramp(20, 1'b0, 0);
    check_pair(status.activePair, 2'h3);
    check_pair({1'b0, status.autoSelect}, 2'h1);
    stop_ramp(20);
    ramp(60, 1'b0, 0);
    check_pair(status.activePair, 2'h0);
    stop_ramp(60);
    rc.rampSwitchFrequency = 12'h000;
    ramp(60, 1'b0, 0);
    check_pair({1'b0, status.autoSelect}, 2'h0);
    stop_ramp(60);
    $display("Test automatic switching done");
    // Coarse units, then analog gain of one half on each input
    rc.rampTimeResolution = 1'b1;
    ramp(60, 1'b0, 0);
    stop_ramp(60);
    rc.rampTimeResolution = 1'b0;
    fn2 = FN_AIN_GAIN;
    gainReq = 12'h400;
    ramp(60, 1'b0, 0);
    stop_ramp(60);
    fn2 = 8'h00;
    fn3 = FN_AIN_GAIN;
    gainReq = 12'hbff;
    ramp(60, 1'b0, 0);
    stop_ramp(60);
    fn3 = 8'h00;
    $display("Test units and gain done");
    // S-curve corners on a full-range ramp
    sc = {8'h14, 8'h14, 8'h0a, 8'h0a};
    ramp(MF, 1'b0, 0);
    stop_ramp(MF);
    sc = '0;
    // Start and stop dwell
    hc = {12'h01e, 7'h01, 12'h014, 7'h01};
    ramp(60, 1'b0, 0);
    stop_ramp(60);
    $display("Test S-curve and dwell done");
    stop_test();
  end
endmodule : mrt_motor_ramp_time_selector_tb
`default_nettype wire

// ==== rtl/mrt_motor_ramp_time_selector.sv ====
// Ramp time selection, S-curve shaping and dwell sequencing.
// Assumes pins are asynchronous and settings come from sys_clk logic.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Four accel and four decel times, one pair
// - Function 7 is bit one, 1A bit two
// - Select changes take effect while running
// - Bits map off/off..on/on to pairs 1..4
// - Auto: output at or above threshold uses pair 1
// - Auto: output below threshold uses pair 4
// - Zero threshold disables automatic switching
// - Analog function 5 scales acceleration time
// - Four S-curve times at ramp corners
// - Accel total is time plus half S-sum
// - Decel total is time plus half S-sum
// - Hold start frequency for start time
// - Terminal select outranks automatic switching
// - Resolution code picks 0.01 or 0.1 s
// - S-curve times limited to 2.50 s
module mrt_motor_ramp_time_selector
  import mrt_pkg::*;
#(
  parameter int          NUM_TERM        = 8,
  parameter int unsigned FINE_UNIT_CYC   = FINE_CYC,
  parameter int unsigned COARSE_UNIT_CYC = COARSE_CYC
) (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  // Terminal pins, asynchronous
  input  wire logic                     runCmdPin,
  input  wire logic [NUM_TERM-1:0]      terminalPin,
  input  wire logic [11:0]              analogInputTwo,
  input  wire logic [11:0]              analogInputThree,
  // Operator settings
  input  wire logic [NUM_TERM-1:0][7:0] digitalInputFunctionSelect,
  input  wire logic [7:0]               analogInTwoFunction,
  input  wire logic [7:0]               analogInThreeFunction,
  input  wire mrt_ramp_cfg_t            rampCfg,
  input  wire mrt_scurve_t              scurveCfg,
  input  wire mrt_hold_cfg_t            holdCfg,
  input  wire logic [11:0]              maxFrequency,
  input  wire logic [11:0]              freqReference,
  // Toward the output stage
  output logic [11:0]                   outFrequency,
  output mrt_status_t                   status
);

  // ---------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------
  generate
    if (NUM_TERM < 1 || NUM_TERM > 16 || FINE_UNIT_CYC < 1 ||
        COARSE_UNIT_CYC < 1 || FINE_UNIT_CYC > 32'h00ffffff ||
        COARSE_UNIT_CYC > 32'h00ffffff) begin : g_bad_param
      $error("mrt: parameter out of range");
    end
  endgenerate

  localparam logic [23:0] FINE_U   = 24'(FINE_UNIT_CYC);
  localparam logic [23:0] COARSE_U = 24'(COARSE_UNIT_CYC);
  localparam int          SW       = NUM_TERM + 25; // Synchroniser width

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [SW-1:0] syncA_reg;  // First stage, read only by syncB_reg
  logic [SW-1:0] syncB_reg;  // Second stage

  // Two flops; analog codes assumed slow next to the clock
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
    end else begin
      syncA_reg <= {runCmdPin, terminalPin, analogInputTwo,
                    analogInputThree};
      syncB_reg <= syncA_reg;
    end
  end

  logic                runCmd;   // Run command, synced
  logic [NUM_TERM-1:0] termLvl;  // Terminal levels, synced
  logic [11:0]         ainTwo;   // Analog input two code
  logic [11:0]         ainThree; // Analog input three code
  assign runCmd   = syncB_reg[SW-1];
  assign termLvl  = syncB_reg[SW-2:24];
  assign ainTwo   = syncB_reg[23:12];
  assign ainThree = syncB_reg[11:0];

  // ---------------------------------------------------------------
  // Terminal function decode
  // ---------------------------------------------------------------
  // Returns {assigned, active} for one function code
  function automatic logic [1:0] termFn(
    input logic [NUM_TERM-1:0]      lvl,
    input logic [NUM_TERM-1:0][7:0] fn,
    input logic [7:0]               code
  );
    logic [1:0] r;
    r = 2'b00;
    for (int i = 0; i < NUM_TERM; i++) begin
      if (fn[i] == code) begin
        r[1] = 1'b1;
        r[0] = r[0] | lvl[i];
      end
    end
    return r;
  endfunction : termFn

  logic [1:0] selOne;       // Select bit one {assigned, on}
  logic [1:0] selTwo;       // Select bit two {assigned, on}
  logic       termAssigned; // Any select function present
  logic       autoOn;       // Automatic switching enabled
  logic [1:0] pairSel;      // Active pair, 0..3
  logic [11:0] out_reg;     // Output frequency

  assign selOne = termFn(termLvl, digitalInputFunctionSelect,
                         FN_SEL_ONE);
  assign selTwo = termFn(termLvl, digitalInputFunctionSelect,
                         FN_SEL_TWO);
  assign termAssigned = selOne[1] | selTwo[1];
  assign autoOn = (rampCfg.rampSwitchFrequency != 12'h000);

  // Pair choice, recomputed every cycle even while running
  always_comb begin
    if (termAssigned) begin
      pairSel = {selTwo[0], selOne[0]};
    end else if (autoOn) begin
      if (out_reg >= rampCfg.rampSwitchFrequency) begin
        pairSel = 2'h0;
      end else begin
        pairSel = 2'h3;
      end
    end else begin
      pairSel = PAIR_RST;
    end
  end

  // ---------------------------------------------------------------
  // Ramp time and S-curve arithmetic
  // ---------------------------------------------------------------
  logic        gainOn;     // Analog gain function selected
  logic [11:0] gainCode;   // Gain code, 2048 = 1.0
  logic [27:0] gainProd;   // Accel time times gain
  logic [16:0] accelEff;   // Effective accel time
  logic [16:0] rampTime;   // Time for current direction
  logic [23:0] unitCyc;    // Cycles per time step
  logic [43:0] tCyc;       // Full-range ramp in cycles
  logic [11:0] target;     // Frequency being ramped to
  logic        dirUp;      // Accelerating
  logic [11:0] remaining;  // Distance to target
  logic [7:0]  sStart;     // Clamped start corner time
  logic [7:0]  sEnd;       // Clamped end corner time
  logic [31:0] sStartCyc;  // Start corner in cycles
  logic [31:0] sEndCyc;    // End corner in cycles
  logic        endRegion;  // Rate must start falling
  logic [6:0]  scale_reg;  // Rate scale, SCALE_FULL is linear

  assign gainOn   = (analogInTwoFunction == FN_AIN_GAIN) ||
                    (analogInThreeFunction == FN_AIN_GAIN);
  assign gainCode = (analogInTwoFunction == FN_AIN_GAIN) ? ainTwo
                                                         : ainThree;
  assign gainProd = 28'(rampCfg.accelTime[pairSel]) * 28'(gainCode);
  assign accelEff = gainOn ? gainProd[GAIN_SHIFT+16:GAIN_SHIFT]
                           : {1'b0, rampCfg.accelTime[pairSel]};
  assign target   = !runCmd ? 12'h000 :
                    (freqReference > maxFrequency) ? maxFrequency
                                                   : freqReference;
  assign dirUp    = target > out_reg;
  assign remaining = dirUp ? 12'(target - out_reg)
                           : 12'(out_reg - target);
  assign rampTime = dirUp ? accelEff
                          : {1'b0, rampCfg.decelTime[pairSel]};
  assign unitCyc  = rampCfg.rampTimeResolution ? COARSE_U : FINE_U;
  assign tCyc     = 44'(rampTime) * 44'(unitCyc);

  // Corner times clamp at the top of their range
  always_comb begin
    sStart = dirUp ? scurveCfg.accStart : scurveCfg.decStart;
    sEnd   = dirUp ? scurveCfg.accEnd   : scurveCfg.decEnd;
    if (sStart > SCRV_LIMIT) sStart = SCRV_LIMIT;
    if (sEnd > SCRV_LIMIT) sEnd = SCRV_LIMIT;
  end
  assign sStartCyc = 32'(sStart) * 32'(FINE_U);
  assign sEndCyc   = 32'(sEnd) * 32'(FINE_U);

  // Rate falls linearly over sEnd: covered distance is s*s*sEnd
  // over 2*FULL^2*tCyc; linear corners add half of each time
  assign endRegion =
    ((72'(remaining) * 72'(tCyc)) << (2 * SCALE_SHIFT + 1)) <=
    (72'(maxFrequency) * 72'(scale_reg) * 72'(scale_reg) *
     72'(sEndCyc));

  // ---------------------------------------------------------------
  // Sequencer and ramp generator
  // ---------------------------------------------------------------
  mrt_state_t  state_reg, state_next;   // Sequencer state
  logic [11:0] out_next;
  logic [51:0] acc_reg, acc_next;       // Rate accumulator
  logic [6:0]  scale_next;
  logic [31:0] sCnt_reg, sCnt_next;     // Scale step timer
  logic [31:0] hold_reg, hold_next;     // Dwell timer
  logic        startDone_reg, startDone_next; // Start dwell used
  logic        stopDone_reg, stopDone_next;   // Stop dwell used
  logic        upLast_reg, upLast_next;       // Last ramp direction
  logic [51:0] accSum;     // Accumulator after this cycle
  logic [51:0] thr;        // One step worth of accumulator
  logic [31:0] sPeriod;    // Cycles per scale step
  logic [31:0] startHoldCyc;
  logic [31:0] stopHoldCyc;
  logic [6:0]  startT;     // Clamped dwell times
  logic [6:0]  stopT;
  logic        startHit;   // Reached start dwell point
  logic        stopHit;    // Reached stop dwell point

  assign startT = (holdCfg.startHoldTime > HOLD_LIMIT) ? HOLD_LIMIT
                                                       : holdCfg.startHoldTime;
  assign stopT  = (holdCfg.stopHoldTime > HOLD_LIMIT) ? HOLD_LIMIT
                                                      : holdCfg.stopHoldTime;
  assign startHoldCyc = 32'(startT) * 32'(COARSE_U);
  assign stopHoldCyc  = 32'(stopT) * 32'(COARSE_U);
  assign thr     = {2'b00, tCyc, 6'b000000};
  assign accSum  = acc_reg + 52'(maxFrequency) * 52'(scale_reg);
  assign sPeriod = (endRegion ? sEndCyc : sStartCyc) >> SCALE_SHIFT;
  assign startHit = !startDone_reg && runCmd && dirUp &&
                    (startT != 7'h00) &&
                    (out_reg >= holdCfg.startHoldFrequency);
  // Stop dwell only exists on a ramped stop
  assign stopHit  = !stopDone_reg && !runCmd && !dirUp &&
                    (stopT != 7'h00) &&
                    (out_reg <= holdCfg.stopHoldFrequency);

  // Next-state logic for sequencer and ramp
  always_comb begin
    state_next     = state_reg;
    out_next       = out_reg;
    acc_next       = acc_reg;
    scale_next     = scale_reg;
    sCnt_next      = sCnt_reg;
    hold_next      = hold_reg;
    startDone_next = startDone_reg;
    stopDone_next  = stopDone_reg;
    upLast_next    = upLast_reg;
    case (state_reg)
      ST_IDLE: begin
        // Stopped: output, rate accumulator and scale parked
        out_next       = OUT_RST;
        acc_next       = '0;
        scale_next     = SCALE_RST;
        startDone_next = 1'b0;
        stopDone_next  = 1'b0;
        if (runCmd) state_next = ST_RAMP;
      end
      ST_RAMP: begin
        if (runCmd) stopDone_next = 1'b0;
        if (startHit) begin
          state_next     = ST_HOLD_START;
          hold_next      = '0;
          startDone_next = 1'b1;
        end else if (stopHit) begin
          state_next    = ST_HOLD_STOP;
          hold_next     = '0;
          stopDone_next = 1'b1;
        end else if (!runCmd && out_reg == 12'h000) begin
          state_next = ST_IDLE;
        end else if (remaining == 12'h000) begin
          // At target: rate rests at zero
          acc_next   = '0;
          scale_next = SCALE_RST;
          sCnt_next  = '0;
        end else if (tCyc == 44'h0) begin
          out_next = target; // Zero time jumps straight there
        end else if (dirUp != upLast_reg) begin
          // Reversal restarts the start corner
          upLast_next = dirUp;
          acc_next    = '0;
          scale_next  = SCALE_RST;
          sCnt_next   = '0;
        end else begin
          sCnt_next = sCnt_reg + 32'h1;
          if (sCnt_reg >= sPeriod) begin
            sCnt_next = '0;
            if (endRegion) begin
              // Floor of one so the ramp always lands
              if (scale_reg > 7'h01) scale_next = scale_reg - 7'h01;
            end else if (sPeriod == 32'h0) begin
              scale_next = SCALE_FULL; // No start corner
            end else if (scale_reg < SCALE_FULL) begin
              scale_next = scale_reg + 7'h01;
            end
          end
          // One step per cycle at most; limits tiny ramp times
          if (accSum >= thr) begin
            acc_next = accSum - thr;
            out_next = dirUp ? out_reg + 12'h001 : out_reg - 12'h001;
          end else begin
            acc_next = accSum;
          end
        end
      end
      ST_HOLD_START: begin
        // Output frozen for the start dwell
        hold_next = hold_reg + 32'h1;
        if (hold_reg + 32'h1 >= startHoldCyc) state_next = ST_RAMP;
      end
      ST_HOLD_STOP: begin
        // Output frozen for the stop dwell; a new run resumes
        hold_next = hold_reg + 32'h1;
        if (runCmd || hold_reg + 32'h1 >= stopHoldCyc) begin
          state_next = ST_RAMP;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  mrt_status_t status_next;  // Status before its flop
  mrt_status_t status_reg;

  always_comb begin
    status_next.state        = state_next;
    status_next.activePair   = pairSel;
    status_next.accelerating = (state_reg == ST_RAMP) && dirUp;
    status_next.holding      = state_next[1];
    status_next.autoSelect   = !termAssigned && autoOn;
  end

  // Registers only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg     <= ST_IDLE;
      out_reg       <= OUT_RST;
      acc_reg       <= '0;
      scale_reg     <= SCALE_RST;
      sCnt_reg      <= '0;
      hold_reg      <= '0;
      startDone_reg <= 1'b0;
      stopDone_reg  <= 1'b0;
      upLast_reg    <= 1'b1;
      status_reg    <= '0;
    end else begin
      state_reg     <= state_next;
      out_reg       <= out_next;
      acc_reg       <= acc_next;
      scale_reg     <= scale_next;
      sCnt_reg      <= sCnt_next;
      hold_reg      <= hold_next;
      startDone_reg <= startDone_next;
      stopDone_reg  <= stopDone_next;
      upLast_reg    <= upLast_next;
      status_reg    <= status_next;
    end
  end

  assign outFrequency = out_reg;
  assign status       = status_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_PAIR_TERM: assert property (
    termAssigned |=> status.activePair == $past({selTwo[0], selOne[0]}))
    else $error("terminal pair mismatch");
  AST_AUTO_HIGH: assert property (
    (!termAssigned && autoOn && out_reg >= rampCfg.rampSwitchFrequency)
    |=> status.activePair == 2'h0) else $error("auto high not pair 1");
  AST_AUTO_LOW: assert property (
    (!termAssigned && autoOn && out_reg < rampCfg.rampSwitchFrequency)
    |=> status.activePair == 2'h3) else $error("auto low not pair 4");
  AST_AUTO_OFF: assert property (
    (!termAssigned && !autoOn) |=> status.activePair == 2'h0)
    else $error("disabled auto not pair 1");
  AST_HOLD_START: assert property (
    state_reg == ST_HOLD_START |=> $stable(outFrequency))
    else $error("output moved in start dwell");
  AST_HOLD_STOP: assert property (
    (state_reg == ST_HOLD_STOP && !runCmd && hold_reg + 32'h1 < stopHoldCyc)
    |=> state_reg == ST_HOLD_STOP && $stable(outFrequency))
    else $error("stop dwell cut short");
  AST_STEP_ONE: assert property (
    (state_reg == ST_RAMP && tCyc != 44'h0) |=>
    (outFrequency == $past(outFrequency) ||
     outFrequency == $past(outFrequency) + 12'h001 ||
     outFrequency == $past(outFrequency) - 12'h001))
    else $error("ramp step larger than one");
  AST_SCALE_MAX: assert property (
    scale_reg <= SCALE_FULL) else $error("rate scale over full");

  COV_START_HOLD: cover property (state_reg == ST_HOLD_START);
  COV_STOP_HOLD: cover property (state_reg == ST_HOLD_STOP);
  COV_AUTO_FOUR: cover property (status.autoSelect &&
                                 status.activePair == 2'h3);
  COV_END_CORNER: cover property (state_reg == ST_RAMP && endRegion);

endmodule : mrt_motor_ramp_time_selector

`default_nettype wire

// ==== rtl/mrt_pkg.sv ====
// Constants, enumerations and carriers for the ramp time selector.
// Assumes one 10 MHz clock and settings held steady by the operator side.
package mrt_pkg;

  // ---------------------------------------------------------------
  // Clock and time units
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 100;    // 10 MHz
  localparam int FINE_STEP_US   = 10000;  // 0.01 s setting step
  localparam int COARSE_STEP_US = 100000; // 0.1 s setting step
  localparam int FINE_CYC   = FINE_STEP_US * 1000 / CLK_PERIOD_NS;
  localparam int COARSE_CYC = COARSE_STEP_US * 1000 / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Setting limits and function codes
  // ---------------------------------------------------------------
  localparam logic [11:0] FREQ_LIMIT  = 12'hfa0; // 400.0 Hz, 0.1 Hz units
  localparam logic [7:0]  SCRV_LIMIT  = 8'hfa;   // 2.50 s, 0.01 s units
  localparam logic [6:0]  HOLD_LIMIT  = 7'h64;   // 10.0 s, 0.1 s units
  localparam logic [7:0]  FN_SEL_ONE  = 8'h07;   // Ramp select bit one
  localparam logic [7:0]  FN_SEL_TWO  = 8'h1a;   // Ramp select bit two
  localparam logic [7:0]  FN_AIN_GAIN = 8'h05;   // Analog time gain
  localparam int          GAIN_SHIFT  = 11;      // Gain code 2048 = 1.0
  localparam logic [6:0]  SCALE_FULL  = 7'h40;   // Full ramp rate
  localparam int          SCALE_SHIFT = 6;       // log2 of SCALE_FULL

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [11:0] OUT_RST   = 12'h000;
  localparam logic [1:0]  PAIR_RST  = 2'h0;
  localparam logic [6:0]  SCALE_RST = 7'h00;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE       = 2'b00,
    ST_RAMP       = 2'b01,
    ST_HOLD_START = 2'b10,
    ST_HOLD_STOP  = 2'b11
  } mrt_state_t;

  // Ramp time table, index 0 is pair 1
  typedef struct packed {
    logic [3:0][15:0] accelTime;
    logic [3:0][15:0] decelTime;
    logic             rampTimeResolution;  // 0: 0.01 s, 1: 0.1 s
    logic [11:0]      rampSwitchFrequency; // 0.1 Hz units
  } mrt_ramp_cfg_t;

  // S-curve times, 0.01 s units
  typedef struct packed {
    logic [7:0] accStart;
    logic [7:0] accEnd;
    logic [7:0] decStart;
    logic [7:0] decEnd;
  } mrt_scurve_t;

  // Dwell settings: 0.1 Hz and 0.1 s units
  typedef struct packed {
    logic [11:0] startHoldFrequency;
    logic [6:0]  startHoldTime;
    logic [11:0] stopHoldFrequency;
    logic [6:0]  stopHoldTime;
  } mrt_hold_cfg_t;

  // Registered status toward the output stage
  typedef struct packed {
    mrt_state_t state;
    logic [1:0] activePair;   // 0..3 for pairs 1..4
    logic       accelerating;
    logic       holding;
    logic       autoSelect;
  } mrt_status_t;

endpackage : mrt_pkg
